// ==== phy_regs_defs.svh ====
// Register offsets, field positions, reset values for the PHY management register bank.
// Assumes inclusion by the register bank module only.
`ifndef PHY_REGS_DEFS_SVH
`define PHY_REGS_DEFS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_PARTNER_ABILITY      5'h05
`define IDX_AUTONEG_EXPANSION    5'h06
`define IDX_RESERVED_LO          5'h08
`define IDX_RESERVED_HI          5'h0F
`define IDX_PHY_STATUS_CONTROL   5'h10
`define IDX_SPECIAL_LINE_CONTROL 5'h11

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EXP_PD_FAULT_BIT   4
`define EXP_LP_NP_BIT      3
`define EXP_LOC_NP_BIT     2
`define EXP_PAGE_RX_BIT    1
`define EXP_LP_AN_BIT      0
`define PSC_RPD_DIS_BIT    13
`define PSC_RW_MASK        16'hF000

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PSC_CTRL_RESET     16'h2000
`define SLC_RESET          16'h0000
`define PWR_DOWN_RESET     2'h3

`endif

// ==== phy_regs_pkg.sv ====
// Types shared by the PHY management register bank.
// Assumes phy_regs_defs.svh sits in the same folder.
package phy_regs_pkg;

   // Remote station advertisement as received
   typedef struct packed {
      logic       next_page;
      logic       ack;
      logic       remote_fault;
      logic [7:0] tech_ability;
      logic [4:0] selector;
   } partner_word_s;

   // Special line control fields, bit 15 down to 0
   typedef struct packed {
      logic scrambler_bypass;
      logic coder_bypass;
      logic force_h_pattern;
      logic force_34_pattern;
      logic force_link_valid;
      logic symbol_err_en;
      logic carrier_sense_dis;
      logic dyn_pwr_down_dis;
      logic an_loopback;
      logic tx_tristate;
      logic force_rev_polarity;
      logic auto_pol_dis;
      logic squelch_test_dis;
      logic ext_squelch_en;
      logic link_integrity_dis;
      logic jabber_dis;
   } line_ctrl_s;

   // Line-side status inputs
   typedef struct packed {
      logic       lp_next_page_able;
      logic       lp_an_able;
      logic       deser_in_sync;
      logic       pwr_down_100;
      logic       pwr_down_10;
      logic       rx_polarity_rev;
      logic       speed_100;
      logic       full_duplex;
   } line_status_s;

endpackage

// ==== phy_regs.sv ====
// Management register bank of a 10/100 PHY, reached over classic Wishbone.
// Assumes line-side inputs come from logic on clk_i; the address strap is a pin.
//
// Contract
// - Partner bit 15 shows remote next page
// - Partner bit 14 shows remote acknowledge
// - Partner bit 13 mirrors remote fault
// - Partner ability and selector fields, read-only
// - Expansion bit 4 latches fault, clears on read
// - Expansion bit 1 latches page, clears on read
// - Expansion bits 3,0 report partner abilities
// - Expansion bit 2 local next page, zero
// - Addresses 8 to 15 hold nothing
// - Status bit 13 disables reduced power-down
// - Status bit 11 shows deserializer sync
// - Status bits 10,9 show unit power-down
// - Status bit 8 shows receive polarity
// - Status bits 6:2 show sampled address
// - Status bits 1,0 show speed, duplex
// - Control bits 15,14 bypass scrambler, coder
// - Control bits 13,12 force test patterns
// - Control bit 11 forces link valid
// - Control bits 10,9 symbol error, carrier sense
// - Control bits 8,7 power-down, loopback
// - Control bits 6,5,4 tristate and polarity
// - Control bits 3:0 squelch, link, jabber
`timescale 1ns/100ps
`include "phy_regs_defs.svh"

module phy_regs
   import phy_regs_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // Wishbone slave
   input  wire logic [6:0]    adr_i,
   input  wire logic [31:0]   dat_i,
   input  wire logic [3:0]    sel_i,
   input  wire logic          we_i,
   input  wire logic          cyc_i,
   input  wire logic          stb_i,
   output logic      [31:0]   dat_o,
   output logic               ack_o,
   // Auto-negotiation side
   input  wire logic          page_valid_i,
   input  wire partner_word_s page_word_i,
   input  wire logic          pd_fault_i,
   input  wire line_status_s  status_i,
   input  wire logic [4:0]    phy_addr_pin_i,
   // Controls toward the line units
   output line_ctrl_s         line_ctrl_o,
   output logic               rpd_disable_o
);

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   partner_word_s partner_r;
   logic          pd_fault_r;
   logic          page_rx_r;
   logic [15:0]   psc_ctrl_r;
   line_ctrl_s    slc_r;
   logic [4:0]    addr_s1_r;
   logic [4:0]    addr_s2_r;
   logic [4:0]    addr_latched_r;
   logic          addr_taken_r;
   logic [15:0]   rd_word;
   logic [15:0]   exp_word;
   logic [15:0]   psc_word;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   function automatic logic hit(input logic [4:0] idx, input logic [4:0] want);
      hit = (idx == want);
   endfunction

   wire logic [4:0]  reg_idx     = adr_i[6:2];
   wire logic        req         = cyc_i && stb_i && !ack_o;
   wire logic        wr_req      = req && we_i;
   wire logic        rd_req      = req && !we_i;
   wire logic        hit_exp     = hit(reg_idx, `IDX_AUTONEG_EXPANSION);
   wire logic        hit_psc     = hit(reg_idx, `IDX_PHY_STATUS_CONTROL);
   wire logic        hit_slc     = hit(reg_idx, `IDX_SPECIAL_LINE_CONTROL);
   wire logic        exp_rd      = rd_req && hit_exp;
   wire logic [15:0] byte_mask   = {{8{sel_i[1]}}, {8{sel_i[0]}}};
   wire logic [15:0] psc_wmask   = byte_mask & `PSC_RW_MASK;
   wire logic [15:0] psc_ctrl_nxt = (psc_ctrl_r & ~psc_wmask) | (dat_i[15:0] & psc_wmask);
   wire logic [15:0] slc_nxt     = (slc_r & ~byte_mask) | (dat_i[15:0] & byte_mask);

   // Expansion word; latched flags sit at their own bit positions
   // partner abilities
   always_comb
   begin
      exp_word = 16'h0000;
      exp_word[`EXP_PD_FAULT_BIT] = pd_fault_r;
      exp_word[`EXP_LP_NP_BIT]    = status_i.lp_next_page_able;
      exp_word[`EXP_LOC_NP_BIT]   = 1'b0;
      exp_word[`EXP_PAGE_RX_BIT]  = page_rx_r;
      exp_word[`EXP_LP_AN_BIT]    = status_i.lp_an_able;
   end

   wire logic psc_unused = 1'b0;
   assign psc_word = {psc_ctrl_r[15:12], status_i.deser_in_sync, status_i.pwr_down_100,
                      status_i.pwr_down_10, status_i.rx_polarity_rev, psc_unused,
                      addr_latched_r, status_i.speed_100, status_i.full_duplex};

   // Read mux; reserved range and unmapped indices read zero
   // nothing behind 8 to 15
   always_comb
   begin
      unique case (1'b1)
         hit(reg_idx, `IDX_PARTNER_ABILITY): rd_word = partner_r;
         hit_exp:                            rd_word = exp_word;
         hit_psc:                            rd_word = psc_word;
         hit_slc:                            rd_word = slc_r;
         default:                            rd_word = 16'h0000;
      endcase
   end

   // ----------------------------------------
   // Bus handshake, one wait-free cycle
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else
      begin
         ack_o <= req;
         dat_o <= rd_req ? {16'h0000, rd_word} : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Partner advertisement capture
   // ----------------------------------------
   // latch received page word
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         partner_r <= '0;
      else if (page_valid_i)
         partner_r <= page_word_i;
   end

   // ----------------------------------------
   // Latched event flags
   // ----------------------------------------
   // fault latch, set beats read clear
   // page latch, set beats read clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pd_fault_r <= 1'b0;
         page_rx_r  <= 1'b0;
      end
      else
      begin
         pd_fault_r <= pd_fault_i || (pd_fault_r && !exp_rd);
         page_rx_r  <= page_valid_i || (page_rx_r && !exp_rd);
      end
   end

   // ----------------------------------------
   // Writable registers
   // ----------------------------------------
   // power-down disable defaults to one
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         psc_ctrl_r <= `PSC_CTRL_RESET;
      else if (wr_req && hit_psc)
         psc_ctrl_r <= psc_ctrl_nxt;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         slc_r <= `SLC_RESET;
      else if (wr_req && hit_slc)
         slc_r <= slc_nxt;
   end

   // Controls leave straight from flops
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         line_ctrl_o   <= `SLC_RESET;
         rpd_disable_o <= 1'b1;
      end
      else
      begin
         line_ctrl_o   <= slc_r;
         rpd_disable_o <= psc_ctrl_r[`PSC_RPD_DIS_BIT];
      end
   end

   // ----------------------------------------
   // Address strap, synchronised then caught once after reset
   // ----------------------------------------
   // sample the address pins
   always_ff @(posedge clk_i)
   begin
      addr_s1_r <= phy_addr_pin_i;
      addr_s2_r <= addr_s1_r;
      if (rst_i)
      begin
         addr_taken_r   <= 1'b0;
         addr_latched_r <= 5'h00;
      end
      else if (!addr_taken_r)
      begin
         addr_taken_r   <= 1'b1;
         addr_latched_r <= addr_s2_r;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_fault_latch_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      pd_fault_i |=> pd_fault_r)
      else $error("fault flag did not latch");

   a_page_clears_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (exp_rd && !page_valid_i) |=> !page_rx_r)
      else $error("page flag not cleared by read");

   a_page_sticks: assert property (@(posedge clk_i) disable iff (rst_i)
      (page_rx_r && !exp_rd) |=> page_rx_r)
      else $error("page flag lost without read");

   a_partner_captured: assert property (@(posedge clk_i) disable iff (rst_i)
      page_valid_i |=> (partner_r == $past(page_word_i)))
      else $error("partner word not captured");

   a_slc_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_req && hit_slc && sel_i[1:0] == 2'h3) |=> ##1 (line_ctrl_o == $past(dat_i[15:0], 2)))
      else $error("control write not reflected");

   a_rpd_follows_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 rpd_disable_o == $past(psc_ctrl_r[`PSC_RPD_DIS_BIT]))
      else $error("power-down disable mismatch");

   a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_req && reg_idx >= `IDX_RESERVED_LO && reg_idx <= `IDX_RESERVED_HI)
      |=> (ack_o && dat_o == 32'h0000_0000))
      else $error("reserved range read nonzero");

   a_ro_bits_kept: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_req && hit_psc) |=> (psc_ctrl_r[11:0] == $past(psc_ctrl_r[11:0])))
      else $error("read-only status bits written");

   a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

   // ----------------------------------------
   // Checks: read path, controls and reset
   // ----------------------------------------
   // fault read clear
   a_fault_clears_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (exp_rd && !pd_fault_i) |=> !pd_fault_r)
      else $error("fault flag not cleared by read");

   a_fault_sticks: assert property (@(posedge clk_i) disable iff (rst_i)
      (pd_fault_r && !exp_rd) |=> pd_fault_r)
      else $error("fault flag lost without read");

   a_page_latch_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      page_valid_i |=> page_rx_r)
      else $error("page flag did not latch");

   a_partner_fault_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      page_valid_i |=> (partner_r.remote_fault == $past(page_word_i.remote_fault)))
      else $error("partner fault bit not mirrored");

   a_partner_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_req && hit(reg_idx, `IDX_PARTNER_ABILITY)) |=> (dat_o[15:0] == $past(partner_r)))
      else $error("partner word read wrong");

   a_partner_stays: assert property (@(posedge clk_i) disable iff (rst_i)
      !page_valid_i |=> $stable(partner_r))
      else $error("partner word changed without page");

   a_exp_flags_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_req && hit_exp) |=> (dat_o[4] == $past(pd_fault_r) && dat_o[1] == $past(page_rx_r)))
      else $error("latched flags read wrong");

   a_exp_fixed_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_req && hit_exp) |=> (dat_o[15:5] == 11'h000 && !dat_o[2]))
      else $error("expansion fixed bits nonzero");

   a_exp_live_bits: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_req && hit_exp) |=> (dat_o[3] == $past(status_i.lp_next_page_able)
         && dat_o[0] == $past(status_i.lp_an_able)))
      else $error("partner ability bits read wrong");

   a_psc_ctrl_bits: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_req && hit_psc) |=> (dat_o[15:12] == $past(psc_ctrl_r[15:12])))
      else $error("status control bits read wrong");

   a_psc_status_live: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_req && hit_psc) |=> (dat_o[11] == $past(status_i.deser_in_sync)
         && dat_o[10] == $past(status_i.pwr_down_100)
         && dat_o[9] == $past(status_i.pwr_down_10)))
      else $error("sync or power bits read wrong");

   a_psc_result_live: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_req && hit_psc) |=> (dat_o[8] == $past(status_i.rx_polarity_rev)
         && dat_o[1] == $past(status_i.speed_100)
         && dat_o[0] == $past(status_i.full_duplex)))
      else $error("polarity or result bits read wrong");

   a_psc_addr_field: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_req && hit_psc) |=> (dat_o[6:2] == $past(addr_latched_r) && !dat_o[7]))
      else $error("address field read wrong");

   a_addr_held: assert property (@(posedge clk_i) disable iff (rst_i)
      addr_taken_r |=> $stable(addr_latched_r))
      else $error("sampled address moved");

   a_slc_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_req && hit_slc) |=> (dat_o[15:0] == $past(slc_r)))
      else $error("control word read wrong");

   a_slc_high_kept: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_req && hit_slc && !sel_i[1]) |=> $stable(slc_r[15:8]))
      else $error("unselected upper lane written");

   a_slc_low_kept: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_req && hit_slc && !sel_i[0]) |=> $stable(slc_r[7:0]))
      else $error("unselected lower lane written");

   a_ctrl_follows_reg: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 (line_ctrl_o == $past(slc_r)))
      else $error("line controls lag register");

   a_reset_values: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> (line_ctrl_o == 16'h0000 && rpd_disable_o
         && psc_ctrl_r == `PSC_CTRL_RESET && !pd_fault_r && !page_rx_r))
      else $error("state wrong after reset");

   a_dat_zero_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      (dat_o[31:16] == 16'h0000 && (ack_o || dat_o[15:0] == 16'h0000)))
      else $error("read data outside answer");

   a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
      req |=> ack_o)
      else $error("request not acknowledged");

endmodule

// ==== line_model.sv ====
// Far-side model: auto-negotiation and line units feeding the register bank.
// Assumes the bench calls its tasks from one process, on the same clock.
`timescale 1ns/100ps
module line_model
   import phy_regs_pkg::*;
(
   input  wire logic          clk_i,
   output logic               page_valid_o,
   output partner_word_s      page_word_o,
   output logic               pd_fault_o,
   output line_status_s       status_o,
   output logic [4:0]         addr_pin_o
);
   // Idle values; strap stays fixed for the whole run, live status changes only through set_status
   initial
   begin
      page_valid_o = 1'b0;
      page_word_o  = 16'h0000;
      pd_fault_o   = 1'b0;
      status_o     = 8'hF6;
      addr_pin_o   = 5'h15;
   end

   // One-cycle page pulse; word is scrambled after so stale data never matches
   task automatic send_page(input logic [15:0] w);
      @(posedge clk_i);
      page_valid_o <= 1'b1;
      page_word_o  <= w;
      @(posedge clk_i);
      page_valid_o <= 1'b0;
      page_word_o  <= ~w;
   endtask

   // One-cycle parallel detection fault
   task automatic raise_fault();
      @(posedge clk_i);
      pd_fault_o <= 1'b1;
      @(posedge clk_i);
      pd_fault_o <= 1'b0;
   endtask

   // Live status change, applied at a clock edge
   task automatic set_status(input line_status_s s);
      @(posedge clk_i);
      status_o <= s;
   endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the PHY management register bank.
// Assumes the line model beside it; only the watchdog ends a hung bus wait.
`timescale 1ns/100ps
module tb;
   import phy_regs_pkg::*;
   logic          clk_i, rst_i, we, cyc, stb, ack, pv, pf, rpd;
   logic [6:0]    adr;
   logic [31:0]   dat_w, dat_r;
   logic [3:0]    sel;
   logic [4:0]    pin;
   logic [15:0]   q, q_hi;
   partner_word_s pw;
   line_status_s  st;
   line_ctrl_s    lc;
   int            failures, total_checks;

   phy_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat_w), .sel_i(sel),
      .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(dat_r), .ack_o(ack), .page_valid_i(pv),
      .page_word_i(pw), .pd_fault_i(pf), .status_i(st), .phy_addr_pin_i(pin),
      .line_ctrl_o(lc), .rpd_disable_o(rpd));
   line_model u_line (.clk_i(clk_i), .page_valid_o(pv), .page_word_o(pw),
      .pd_fault_o(pf), .status_o(st), .addr_pin_o(pin));

   // ----------------------------------------
   // Bus and report tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Classic cycle; request held until ack is sampled high
   task automatic bus(input logic w, input logic [6:0] a, input logic [15:0] d,
                      input logic [3:0] s);
      @(posedge clk_i);
      {cyc, stb, we, adr, dat_w, sel} <= {2'b11, w, a, 16'h0000, d, s};
      do
      begin
         @(posedge clk_i);
      end
      while (ack !== 1'b1);
      q    = dat_r[15:0];
      q_hi = dat_r[31:16];
      {cyc, stb, we} <= 3'b000;
   endtask

   task automatic rd(input logic [6:0] a, input logic [15:0] exp, input string name);
      bus(1'b0, a, 16'h0000, 4'h0);
      check(name, q, exp);
      check("dat_hi", q_hi, 16'h0000);
   endtask

   // Controls land one edge after the taken edge; look after one more
   task automatic outs(input logic [15:0] exp_lc, input logic exp_rpd);
      @(posedge clk_i);
      #1;
      check("line_ctrl", lc, exp_lc);
      check("rpd_disable", {15'h0000, rpd}, {15'h0000, exp_rpd});
   endtask

   task automatic complete_run();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // Watchdog well beyond the roughly 160 cycles the tests need
   initial
   begin
      #200000;
      failures++;
      complete_run();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {rst_i, cyc, stb, we, adr, dat_w, sel} = {1'b1, 3'b000, 7'h00, 32'h0, 4'h0};
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd(7'h40, 16'h2D56, "status");
      rd(7'h44, 16'h0000, "ctrl");
      rd(7'h18, 16'h0009, "expansion");
      bus(1'b1, 7'h44, 16'hFFFF, 4'h3);
      rd(7'h44, 16'hFFFF, "ctrl");
      outs(16'hFFFF, 1'b1);
      bus(1'b1, 7'h44, 16'h5A5A, 4'h3);
      // Low lane only: upper byte must survive
      bus(1'b1, 7'h44, 16'h0000, 4'h1);
      rd(7'h44, 16'h5A00, "ctrl");
      bus(1'b1, 7'h40, 16'h0000, 4'h3);
      rd(7'h40, 16'h0D56, "status");
      outs(16'h5A00, 1'b0);
      bus(1'b1, 7'h40, 16'hFFFF, 4'h3);
      rd(7'h40, 16'hFD56, "status");
      bus(1'b1, 7'h18, 16'hFFFF, 4'h3);
      rd(7'h18, 16'h0009, "expansion");
      // Reserved block plus one far unmapped index
      for (int i = 8; i <= 16; i++)
      begin
         bus(1'b1, (i == 16) ? 7'h7C : 7'(i * 4), 16'hFFFF, 4'h3);
         rd((i == 16) ? 7'h7C : 7'(i * 4), 16'h0000, "reserved");
      end
      u_line.send_page(16'hA5C3);
      rd(7'h14, 16'hA5C3, "partner");
      rd(7'h18, 16'h000B, "expansion");
      rd(7'h18, 16'h0009, "expansion");
      bus(1'b1, 7'h14, 16'h0000, 4'h3);
      rd(7'h14, 16'hA5C3, "partner");
      u_line.raise_fault();
      rd(7'h18, 16'h0019, "expansion");
      rd(7'h18, 16'h0009, "expansion");
      // Flip every live status input so no field can pass by being stuck
      u_line.set_status(8'h09);
      rd(7'h18, 16'h0000, "expansion");
      rd(7'h40, 16'hF255, "status");
      // Mid-run reset with a fault pending and controls set
      u_line.raise_fault();
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(7'h18, 16'h0000, "expansion");
      rd(7'h40, 16'h2255, "status");
      rd(7'h44, 16'h0000, "ctrl");
      outs(16'h0000, 1'b1);
      complete_run();
   end
endmodule
